// ### hw/nsg_regs.vh
// constants for the nvm section access guard
// assumes a 64 KB flash, byte addressed, fuses counting 256-byte blocks
`ifndef NSG_REGS_VH
`define NSG_REGS_VH
`define NSG_CTRL_ADDR 4'h0
`define NSG_FUSE_ADDR 4'h4
`define NSG_STAT_ADDR 4'h8
`define NSG_BND_ADDR 4'hC
`define NSG_CTRL_RST 5'h00
`define NSG_B_EE_WP 0
`define NSG_B_DATA_WP 1
`define NSG_B_CODE_WP 2
`define NSG_B_RD_LOCK 3
`define NSG_B_VSEL 4
`define NSG_FLASH_SIZE 17'h10000
`define NSG_FLASH_AW 16
`define NSG_HALT_BASE 16'hE000
`define NSG_BLK_SHIFT 8
`define NSG_PAGE_MASK 16'hFF80
`define NSG_ROW_MASK 16'hFFC0
`define NSG_EE_PAGE_MASK 16'hFFE0
`define NSG_EE_IDX_W 5
`define NSG_EE_PAGE_BYTES 32
`define NSG_EE_ADDR_MASK 16'h01FF
`define NSG_FUSE_DEF 8'h00
`define NSG_SEC_LOADER 2'h0
`define NSG_SEC_CODE 2'h1
`define NSG_SEC_DATA 2'h2
`define NSG_TGT_FLASH 3'h0
`define NSG_TGT_EE 3'h1
`define NSG_TGT_SPARE 3'h2
`define NSG_TGT_SIG 3'h3
`define NSG_TGT_FUSE 3'h4
`define NSG_OP_ERASE 2'h0
`define NSG_OP_WRITE 2'h1
`define NSG_OP_ERWR 2'h2
`define NSG_OP_CHIP 2'h3
`define NSG_OP_TIME_NS 4000
`define NSG_CLK_NS 50
`define NSG_RESP_OK 2'h0
`define NSG_RESP_ERR 2'h2
`endif

// ### hw/nsg_guard.v
// nvm section access guard: stall, section decode, protection, axi4-lite regs
// assumes cpu and programming port logic share aclk; memory arrays sit outside
`timescale 1ns/1ps
`include "nsg_regs.vh"
module nsg_guard
(
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [15:0] cpu_pc,
	input wire cpu_acc_valid,
	input wire cpu_acc_flash,
	input wire [15:0] cpu_acc_addr,
	output wire cpu_stall,
	output wire cpu_acc_deny,
	input wire ee_buf_we,
	input wire [15:0] ee_buf_addr,
	input wire req_valid,
	input wire req_from_port,
	input wire [2:0] req_tgt,
	input wire [1:0] req_op,
	input wire [15:0] req_addr,
	input wire dev_locked,
	input wire port_fuse_we,
	input wire port_fuse_sel,
	input wire [7:0] port_fuse_data,
	output reg req_refused,
	output reg nvm_go,
	output reg [2:0] nvm_tgt,
	output reg [1:0] nvm_op,
	output reg [15:0] nvm_addr,
	output reg [31:0] ee_mask,
	output wire nvm_busy,
	output reg [15:0] vec_base
);
	localparam ST_IDLE = 1'b0;
	localparam ST_BUSY = 1'b1;
	localparam integer OP_CYC_I = `NSG_OP_TIME_NS / `NSG_CLK_NS;
	localparam [15:0] OP_CYC = OP_CYC_I[15:0];

	reg st_r;
	reg [15:0] cnt_r;
	reg halt_op_r;
	reg [4:0] ctrl_r;
	reg [7:0] fuse_lsz_r;
	reg [7:0] fuse_csz_r;
	reg [7:0] lsz_r;
	reg [7:0] csz_r;
	reg loaded_r;
	reg [31:0] mark_r;
	reg refused_r;
	reg aw_got_r;
	reg w_got_r;
	reg [3:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;

	wire [16:0] lend_raw;
	wire [16:0] cend_raw;
	wire [7:0] lsz_eff;
	wire [7:0] csz_eff;
	wire [16:0] lend;
	reg [16:0] cend;
	reg [1:0] exec_sec;
	reg [1:0] tgt_sec;
	reg [1:0] acc_sec;
	reg allow;
	wire acc_conc;
	wire tgt_halt;
	wire [`NSG_EE_IDX_W-1:0] mark_idx;

	// classify a flash address into loader, code or data section
	function [1:0] sec_of;
		input [15:0] a;
		input [7:0] ls;
		input [16:0] le;
		input [16:0] ce;
		begin
			if (ls == `NSG_FUSE_DEF || {1'b0, a} < le)
				sec_of = `NSG_SEC_LOADER;
			else if ({1'b0, a} < ce)
				sec_of = `NSG_SEC_CODE;
			else
				sec_of = `NSG_SEC_DATA;
		end
	endfunction

	assign lend_raw = {1'b0, lsz_r, 8'h00};
	assign cend_raw = {1'b0, csz_r, 8'h00};
	assign lsz_eff = (lend_raw > `NSG_FLASH_SIZE) ? `NSG_FUSE_DEF : lsz_r;
	assign csz_eff = (cend_raw > `NSG_FLASH_SIZE) ? `NSG_FUSE_DEF : csz_r;
	assign lend = {1'b0, lsz_eff, 8'h00};

	always @*
	begin
		// zero code size to flash end
		if (csz_eff == `NSG_FUSE_DEF)
			cend = `NSG_FLASH_SIZE;
		else if (csz_eff <= lsz_eff)
			cend = lend;
		else
			cend = {1'b0, csz_eff, 8'h00};
	end

	always @*
	begin
		exec_sec = sec_of(cpu_pc, lsz_eff, lend, cend);
		tgt_sec = sec_of(req_addr, lsz_eff, lend, cend);
		acc_sec = sec_of(cpu_acc_addr, lsz_eff, lend, cend);
	end

	// which party may program which memory
	always @*
	begin
		allow = 1'b0;
		if (req_tgt == `NSG_TGT_SIG)
			allow = 1'b0;
		else if (req_from_port)
		begin
			if (req_tgt == `NSG_TGT_SPARE)
				allow = 1'b1;
			else
				allow = !dev_locked;
		end
		else if (req_tgt == `NSG_TGT_FUSE || req_op == `NSG_OP_CHIP)
			allow = 1'b0;
		else if (exec_sec == `NSG_SEC_DATA)
			allow = 1'b0;
		else if (req_tgt == `NSG_TGT_EE)
			allow = !ctrl_r[`NSG_B_EE_WP];
		else if (req_tgt == `NSG_TGT_SPARE)
			allow = 1'b1;
		else if (tgt_sec == `NSG_SEC_LOADER)
			allow = 1'b0;
		else if (tgt_sec == `NSG_SEC_CODE)
			allow = exec_sec == `NSG_SEC_LOADER && !ctrl_r[`NSG_B_CODE_WP];
		else
			allow = !ctrl_r[`NSG_B_DATA_WP];
		// combined erase-write is an eeprom-only operation
		if (req_op == `NSG_OP_ERWR && req_tgt != `NSG_TGT_EE)
			allow = 1'b0;
	end

	assign tgt_halt = req_tgt == `NSG_TGT_FLASH && req_addr >= `NSG_HALT_BASE;
	assign acc_conc = cpu_acc_addr < `NSG_HALT_BASE;
	assign nvm_busy = st_r;

	assign cpu_stall = st_r && (halt_op_r || (cpu_acc_valid && cpu_acc_flash && acc_conc));

	assign cpu_acc_deny = cpu_acc_valid && cpu_acc_flash && ctrl_r[`NSG_B_RD_LOCK]
		&& acc_sec == `NSG_SEC_LOADER && exec_sec != `NSG_SEC_LOADER;

	assign mark_idx = ee_buf_addr[`NSG_EE_IDX_W-1:0];

	// operation sequencer
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= ST_IDLE;
			cnt_r <= 16'h0000;
			halt_op_r <= 1'b0;
			nvm_go <= 1'b0;
			nvm_tgt <= 3'h0;
			nvm_op <= 2'h0;
			nvm_addr <= 16'h0000;
			ee_mask <= 32'h00000000;
			mark_r <= 32'h00000000;
			req_refused <= 1'b0;
			refused_r <= 1'b0;
		end
		else if (clk_en)
		begin
			nvm_go <= 1'b0;
			req_refused <= 1'b0;
			case (st_r)
				ST_IDLE:
				begin
					if (req_valid && allow)
					begin
						st_r <= ST_BUSY;
						cnt_r <= OP_CYC;
						halt_op_r <= tgt_halt || req_op == `NSG_OP_CHIP;
						nvm_go <= 1'b1;
						nvm_tgt <= req_tgt;
						nvm_op <= req_op;
						if (req_tgt == `NSG_TGT_FLASH)
							nvm_addr <= req_addr & `NSG_PAGE_MASK;
						// spare row erased as a row
						else if (req_tgt == `NSG_TGT_SPARE)
							nvm_addr <= req_addr & `NSG_ROW_MASK;
						else if (req_tgt == `NSG_TGT_EE)
							nvm_addr <= req_addr & `NSG_EE_PAGE_MASK & `NSG_EE_ADDR_MASK;
						else
							nvm_addr <= req_addr;
						ee_mask <= (req_tgt == `NSG_TGT_EE) ? mark_r : 32'h00000000;
					end
					else if (req_valid)
					begin
						req_refused <= 1'b1;
						refused_r <= 1'b1;
					end
				end
				ST_BUSY:
				begin
					// requests during an operation are refused too
					if (req_valid)
					begin
						req_refused <= 1'b1;
						refused_r <= 1'b1;
					end
					if (cnt_r == 16'h0001)
					begin
						st_r <= ST_IDLE;
						halt_op_r <= 1'b0;
					end
					cnt_r <= cnt_r - 16'h0001;
				end
				default: st_r <= ST_IDLE;
			endcase
			// mark buffered eeprom bytes; a new mark wins over the clear
			if (st_r == ST_IDLE && req_valid && allow && req_tgt == `NSG_TGT_EE)
				mark_r <= ee_buf_we ? (32'h00000001 << mark_idx) : 32'h00000000;
			else if (ee_buf_we)
				mark_r <= mark_r | (32'h00000001 << mark_idx);
			if (aw_got_r && w_got_r && !s_axi_bvalid && aw_addr_r == `NSG_STAT_ADDR
				&& w_strb_r[0] && w_data_r[1] && !(req_valid && st_r == ST_BUSY)
				&& !(req_valid && st_r == ST_IDLE && !allow))
				refused_r <= 1'b0;
		end
	end

	// fuse cells are nonvolatile: a system reset must not clear them
	initial fuse_lsz_r = `NSG_FUSE_DEF;
	initial fuse_csz_r = `NSG_FUSE_DEF;

	// fuse storage and start-up copy
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lsz_r <= `NSG_FUSE_DEF;
			csz_r <= `NSG_FUSE_DEF;
			loaded_r <= 1'b0;
			vec_base <= 16'h0000;
		end
		else if (clk_en)
		begin
			if (port_fuse_we && !port_fuse_sel)
				fuse_lsz_r <= port_fuse_data;
			if (port_fuse_we && port_fuse_sel)
				fuse_csz_r <= port_fuse_data;
			// copy once at end of start-up
			if (!loaded_r)
			begin
				lsz_r <= fuse_lsz_r;
				csz_r <= fuse_csz_r;
				loaded_r <= 1'b1;
			end
			if (ctrl_r[`NSG_B_VSEL])
				vec_base <= 16'h0000;
			else
				vec_base <= lend[15:0];
		end
	end

	// axi4-lite write side: address and data taken in either order
	assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
	assign s_axi_wready = !w_got_r && !s_axi_bvalid;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= 4'h0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `NSG_RESP_OK;
			ctrl_r <= `NSG_CTRL_RST;
		end
		else if (clk_en)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (aw_got_r && w_got_r && !s_axi_bvalid)
			begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `NSG_RESP_OK;
				if (aw_addr_r == `NSG_CTRL_ADDR)
				begin
					if (w_strb_r[0])
					begin
						ctrl_r[2:0] <= w_data_r[2:0];
						ctrl_r[`NSG_B_VSEL] <= w_data_r[`NSG_B_VSEL];
						// lock set only from loader, sticky
						if (w_data_r[`NSG_B_RD_LOCK] && exec_sec == `NSG_SEC_LOADER)
							ctrl_r[`NSG_B_RD_LOCK] <= 1'b1;
					end
				end
				else if (aw_addr_r == `NSG_STAT_ADDR)
					s_axi_bresp <= `NSG_RESP_OK;
				else
					// fuse and bounds words refuse cpu writes
					s_axi_bresp <= `NSG_RESP_ERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// axi4-lite read side
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `NSG_RESP_OK;
		end
		else if (clk_en)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `NSG_RESP_OK;
				if (s_axi_araddr[3:2] == `NSG_CTRL_ADDR >> 2)
					s_axi_rdata <= {27'h0000000, ctrl_r};
				else if (s_axi_araddr[3:2] == `NSG_FUSE_ADDR >> 2)
					s_axi_rdata <= {16'h0000, csz_r, lsz_r};
				else if (s_axi_araddr[3:2] == `NSG_STAT_ADDR >> 2)
					s_axi_rdata <= {28'h0000000, exec_sec, refused_r, st_r};
				else
					s_axi_rdata <= {cend[15:0], lend[15:0]};
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // nsg_guard

// ### sim/nsg_guard_properties.sv
// assertions on nsg_guard ports: stalls, request answers, refusals
// assumes clk_en is held high and one clock domain
`timescale 1ns/1ps
`include "nsg_regs.vh"
module nsg_props
(
	input wire aclk,
	input wire aresetn,
	input wire cpu_acc_valid,
	input wire cpu_acc_flash,
	input wire [15:0] cpu_acc_addr,
	input wire cpu_stall,
	input wire req_valid,
	input wire req_from_port,
	input wire [2:0] req_tgt,
	input wire req_refused,
	input wire nvm_go,
	input wire [2:0] nvm_tgt,
	input wire [1:0] nvm_op,
	input wire [15:0] nvm_addr,
	input wire nvm_busy
);
reg halt_r;
reg [7:0] cnt_r;
wire acc = cpu_acc_valid && cpu_acc_flash;
wire hi = cpu_acc_addr >= `NSG_HALT_BASE;
// the go cycle already counts, so the new kind is used at once
wire hop = nvm_go ? nvm_op == `NSG_OP_CHIP
	|| nvm_tgt == `NSG_TGT_FLASH && nvm_addr >= `NSG_HALT_BASE : halt_r;
always @(posedge aclk)
	if (!aresetn)
	begin
		halt_r <= 1'b0;
		cnt_r <= 8'h00;
	end
	else
	begin
		halt_r <= hop;
		cnt_r <= nvm_go ? 8'h01 : cnt_r + {7'h00, nvm_busy};
	end
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
conc_runs_a: assert property (nvm_busy && !hop && acc && hi |-> !cpu_stall)
	else $error("halting read stalled");
halt_stall_a: assert property (nvm_busy && hop && acc |-> cpu_stall)
	else $error("cpu ran during halting op");
conc_stall_a: assert property (nvm_busy && acc && !hi |-> cpu_stall)
	else $error("concurrent read ran");
req_answer_a: assert property (req_valid |=> nvm_go != req_refused)
	else $error("request answer wrong");
op_length_a: assert property ($fell(nvm_busy) |-> cnt_r == 8'h50)
	else $error("operation length wrong");
busy_refuse_a: assert property (req_valid && nvm_busy
	&& cnt_r < 8'h46 |=> req_refused && !nvm_go) else $error("busy request taken");
sig_refuse_a: assert property (req_valid
	&& req_tgt == `NSG_TGT_SIG |=> req_refused) else $error("signature write taken");
fuse_refuse_a: assert property (req_valid && !req_from_port
	&& req_tgt == `NSG_TGT_FUSE |=> req_refused) else $error("cpu fuse write taken");
endmodule // nsg_props
bind nsg_guard nsg_props chk_u (.aclk(aclk), .aresetn(aresetn), .cpu_acc_valid(cpu_acc_valid),
	.cpu_acc_flash(cpu_acc_flash), .cpu_acc_addr(cpu_acc_addr), .cpu_stall(cpu_stall),
	.req_valid(req_valid), .req_from_port(req_from_port), .req_tgt(req_tgt),
	.req_refused(req_refused), .nvm_go(nvm_go), .nvm_tgt(nvm_tgt), .nvm_op(nvm_op),
	.nvm_addr(nvm_addr), .nvm_busy(nvm_busy));

// ### sim/nsg_cpu.sv
// cpu partner: one flash access at a time, held while stalled
// assumes the bench pulses start for one cycle
`timescale 1ns/1ps
module nsg_cpu
(
	input wire aclk,
	input wire start,
	input wire [15:0] a,
	input wire stall,
	output reg valid,
	output reg [15:0] addr
);
initial valid = 1'b0;
initial addr = 16'h0000;
always @(posedge aclk)
	if (start)
	begin
		valid <= 1'b1;
		addr <= a;
	end
	else if (valid && !stall)
	begin
		valid <= 1'b0;
		// released bus must not look like a held address
		addr <= ~addr;
	end
endmodule // nsg_cpu

// ### sim/tb.sv
// self-checking bench for nsg_guard with a cpu partner
// assumes the checker binds itself; fuses of 4 and 8 blocks
`timescale 1ns/1ps
`include "nsg_regs.vh"
module tb;
localparam [7:0] LF = 8'h04;
localparam [7:0] CF = 8'h08;
localparam FL = `NSG_TGT_FLASH;
localparam WR = `NSG_OP_WRITE;
reg aclk, aresetn, awv, wv, brd, arv, rrd, rqv, rfp, fwe, fsel, ebw, lck, cgo;
reg [3:0] awa, ara;
reg [31:0] wd, lf, d, m;
reg [2:0] t;
reg [2:0] rt;
reg ah, wh, bh;
reg [1:0] bs;
reg [1:0] ro;
reg [15:0] ra, eba, ca, pc, ea;
reg [7:0] fd;
wire awr, wry, arr, bv, rv, stl, dny, rf, go, bsy, cv;
wire [1:0] br, ot, rr;
wire [2:0] tg;
wire [31:0] rd, em;
wire [15:0] cad, vb, na;
integer failures, checks_done, i, j;
nsg_guard dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awa),
	.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
	.s_axi_wvalid(wv), .s_axi_wready(wry), .s_axi_bresp(br), .s_axi_bvalid(bv),
	.s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
	.s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .cpu_pc(pc),
	.cpu_acc_valid(cv), .cpu_acc_flash(1'b1), .cpu_acc_addr(cad), .cpu_stall(stl),
	.cpu_acc_deny(dny), .ee_buf_we(ebw), .ee_buf_addr(eba), .req_valid(rqv),
	.req_from_port(rfp), .req_tgt(rt), .req_op(ro), .req_addr(ra), .dev_locked(lck),
	.port_fuse_we(fwe), .port_fuse_sel(fsel), .port_fuse_data(fd), .req_refused(rf),
	.nvm_go(go), .nvm_tgt(tg), .nvm_op(ot), .nvm_addr(na), .ee_mask(em), .nvm_busy(bsy),
	.vec_base(vb));
nsg_cpu cpu_u (.aclk(aclk), .start(cgo), .a(ca), .stall(stl), .valid(cv), .addr(cad));
initial
begin
	aclk = 1'b0;
	forever #25 aclk = ~aclk;
end
function [31:0] nx(input [31:0] v);
	nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task ck(input [31:0] s, input [31:0] e, input [63:0] n);
begin
	checks_done = checks_done + 1;
	if (s !== e)
	begin
		failures = failures + 1;
		$display("BAD %0s exp %h seen %h", n, e, s);
	end
end
endtask
task give_verdict;
begin
	$display("checks %0d failures %0d", checks_done, failures);
	if (failures == 0 && checks_done > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
end
endtask
task rst;
begin
	aresetn <= 1'b0;
	repeat (8) @(posedge aclk);
	aresetn <= 1'b1;
end
endtask
task wrr(input [3:0] a, input [31:0] v, input [1:0] e);
begin
	@(posedge aclk);
	{awa, wd, awv, wv, brd} <= {a, v, 3'b111};
	bh = 1'b0;
	// handshakes are judged mid-cycle, where ready levels have settled
	while (!bh)
	begin
		@(negedge aclk);
		{ah, wh, bh, bs} = {awv & awr, wv & wry, bv, br};
		@(posedge aclk);
		if (ah)
			awv <= 1'b0;
		if (wh)
			wv <= 1'b0;
	end
	brd <= 1'b0;
	ck(32'(bs), 32'(e), "bresp");
end
endtask
task rdr(input [3:0] a);
begin
	@(posedge aclk);
	{ara, arv, rrd} <= {a, 2'b11};
	bh = 1'b0;
	while (!bh)
	begin
		@(negedge aclk);
		{ah, bh, bs} = {arv & arr, rv, rr};
		d = rd;
		@(posedge aclk);
		if (ah)
			arv <= 1'b0;
	end
	rrd <= 1'b0;
	ck(32'(bs), 32'(`NSG_RESP_OK), "rresp");
end
endtask
task fz(input s, input [7:0] v);
begin
	@(posedge aclk);
	{fwe, fsel, fd} <= {1'b1, s, v};
	@(posedge aclk);
	fwe <= 1'b0;
end
endtask
task mk(input [4:0] b);
begin
	@(posedge aclk);
	{ebw, eba} <= {1'b1, 11'h000, b};
	@(posedge aclk);
	ebw <= 1'b0;
end
endtask
task acc(input [15:0] a, input es, input ed);
begin
	@(posedge aclk);
	{cgo, ca} <= {1'b1, a};
	@(posedge aclk);
	cgo <= 1'b0;
	// combinational levels are looked at mid-cycle, while the access stands
	@(negedge aclk);
	ck(32'(stl), 32'(es), "stall");
	ck(32'(dny), 32'(ed), "deny");
	@(posedge aclk);
end
endtask
task iss(input [2:0] tt, input [1:0] o, input [15:0] a);
begin
	@(posedge aclk);
	{rqv, rt, ro, ra} <= {1'b1, tt, o, a};
	@(posedge aclk);
	rqv <= 1'b0;
	// answer pulses stand for one cycle only
	@(negedge aclk);
end
endtask
task rq(input [2:0] tt, input [1:0] o, input [15:0] a, input ok, input [15:0] c, input es);
begin
	iss(tt, o, a);
	ck(32'(go), 32'(ok), "go");
	ck(32'(rf), 32'(!ok), "refused");
	if (ok)
	begin
		ck({27'h0, tg, ot}, {27'h0, tt, o}, "op");
		ea = tt == FL ? `NSG_PAGE_MASK : tt == `NSG_TGT_SPARE ? `NSG_ROW_MASK
			: `NSG_EE_PAGE_MASK & `NSG_EE_ADDR_MASK;
		ck(32'(na), 32'(a & ea), "addr");
	end
	acc(c, es & ok, 1'b0);
	if (ok)
	begin
		iss(tt, o, a);
		ck(32'(rf), 1, "busy_ref");
	end
	@(posedge aclk);
	while (bsy) @(posedge aclk);
end
endtask
initial
begin
	{aresetn, awv, wv, brd, arv, rrd, rqv, rfp, fwe, fsel, ebw, lck, cgo} = 13'h0;
	{awa, ara, wd, rt, ro, ra, eba, ca, pc, fd} = 117'h0;
	{failures, checks_done, lf} = {32'h0, 32'h0, 32'h1219};
	rst;
	ck(32'(vb), 0, "vec0");
	pc <= 16'h0100;
	rq(FL, WR, 16'hA000, 1'b0, 16'hE100, 1'b0);
	fz(1'b0, LF);
	fz(1'b1, CF);
	rst;
	rdr(`NSG_BND_ADDR);
	ck(d, {CF, 8'h00, LF, 8'h00}, "bounds");
	ck(32'(vb), {16'h0, LF, 8'h00}, "vec");
	wrr(`NSG_CTRL_ADDR, 32'h10, `NSG_RESP_OK);
	repeat (2) @(posedge aclk);
	ck(32'(vb), 0, "vecsel");
	wrr(`NSG_CTRL_ADDR, 0, `NSG_RESP_OK);
	wrr(`NSG_FUSE_ADDR, 1, `NSG_RESP_ERR);
	rdr(`NSG_FUSE_ADDR);
	ck(d, {16'h0, CF, LF}, "fuse");
	// every execution section against the flash sections, eeprom and spare row
	for (i = 0; i < 3; i = i + 1)
	begin
		pc <= {4'h0, i[1:0], 10'h100};
		rdr(`NSG_STAT_ADDR);
		ck(32'(d[3:2]), i, "exec");
		for (j = 0; j < 5; j = j + 1)
		begin
			lf = nx(lf);
			m = (32'h1 << lf[4:0]) | (32'h1 << lf[12:8]);
			if (j == 3)
			begin
				mk(lf[4:0]);
				mk(lf[12:8]);
			end
			t = j < 3 ? FL : j == 3 ? `NSG_TGT_EE : `NSG_TGT_SPARE;
			rq(t, j == 4 ? `NSG_OP_ERASE : j == 3 && i == 0 ? `NSG_OP_ERWR : WR,
				j < 3 ? {4'h0, j[1:0], 3'h4, lf[6:0]} : {8'h00, lf[23:16]},
				i < 2 && (j < 3 ? j : 2) > i, j[0] ? 16'h0100 : 16'hE100, j[0]);
			if (j == 3 && i < 2)
				ck(em, m, "eemask");
		end
	end
	// back in the loader, which may program the halting area
	pc <= 16'h0100;
	rq(FL, WR, 16'hE000, 1'b1, 16'hE100, 1'b1);
	for (i = 0; i < 3; i = i + 1)
	begin
		wrr(`NSG_CTRL_ADDR, 32'h1 << i, `NSG_RESP_OK);
		rq(i ? FL : `NSG_TGT_EE, WR, i == 1 ? 16'h0A00 : 16'h0600, 1'b0, 16'hE100, 1'b0);
	end
	wrr(`NSG_CTRL_ADDR, 0, `NSG_RESP_OK);
	{rfp, lck} <= 2'b11;
	rq(`NSG_TGT_SPARE, `NSG_OP_ERASE, 16'h0000, 1'b1, 16'hE100, 1'b0);
	rq(`NSG_TGT_SIG, WR, 16'h0000, 1'b0, 16'hE100, 1'b0);
	lck <= 1'b0;
	rq(FL, `NSG_OP_CHIP, 16'h0000, 1'b1, 16'hE100, 1'b1);
	rfp <= 1'b0;
	rq(`NSG_TGT_FUSE, WR, 16'h0000, 1'b0, 16'hE100, 1'b0);
	wrr(`NSG_CTRL_ADDR, 32'h8, `NSG_RESP_OK);
	acc(16'h0100, 1'b0, 1'b0);
	pc <= 16'h0500;
	acc(16'h0100, 1'b0, 1'b1);
	give_verdict;
end
initial
begin
	repeat (20000) @(posedge aclk);
	failures = failures + 1;
	give_verdict;
end
endmodule // tb
